// ### uart_irq_pkg.sv
/*
 * constants shared by the channel interrupt / port-pin block:
 * register offsets, field positions, reset values, codes.
 * assumes byte addressing on a 32-bit classic wishbone bus.
 */
package uart_irq_pkg;

    // register byte offsets
    localparam logic [5:0] OFS_LOW_SEL   = 6'h00;
    localparam logic [5:0] OFS_HIGH_SEL  = 6'h04;
    localparam logic [5:0] OFS_FLAGS     = 6'h08;
    localparam logic [5:0] OFS_ENABLES   = 6'h0C;
    localparam logic [5:0] OFS_MODE      = 6'h10;
    localparam logic [5:0] OFS_OUT_LATCH = 6'h14;
    localparam logic [5:0] OFS_IN_PORT   = 6'h18;
    localparam logic [5:0] OFS_COMMAND   = 6'h1C;
    localparam logic [5:0] OFS_EVT_FLAGS = 6'h20;
    localparam logic [5:0] OFS_EVT_MASK  = 6'h24;
    localparam logic [5:0] OFS_FLOW_STAT = 6'h28;

    // mode register fields
    localparam int MODE_MASKED_READ_BIT = 0;
    localparam int MODE_RX_TRIG_LSB     = 2;
    localparam int MODE_TX_TRIG_LSB     = 4;

    // status bit positions
    localparam int ST_INPUT_CHANGE = 7;
    localparam int ST_WATCHDOG     = 6;
    localparam int ST_ADDR_MATCH   = 5;
    localparam int ST_FLOW_CHAR    = 4;
    localparam int ST_RESERVED     = 3;
    localparam int ST_BREAK        = 2;
    localparam int ST_RX_READY     = 1;
    localparam int ST_TX_READY     = 0;

    // command codes, low five bits of the command port
    localparam logic [4:0] CMD_RESET_ADDR_STATUS  = 5'h1B;
    localparam logic [4:0] CMD_RESET_BREAK_CHANGE = 5'h05;

    // idle receiver bit times before the watchdog fires
    localparam logic [6:0] WATCHDOG_BIT_TIMES = 7'h40;

    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;

    typedef enum logic [1:0] {
        PIN_INPUT    = 2'b00,
        PIN_LATCH    = 2'b01,
        PIN_FUNCTION = 2'b10,
        PIN_RESERVED = 2'b11
    } pin_mode_t;

    typedef enum logic [1:0] {
        RX_TRIG_READY = 2'b00,
        RX_TRIG_HALF  = 2'b01,
        RX_TRIG_3Q    = 2'b10,
        RX_TRIG_FULL  = 2'b11
    } rx_trig_t;

    typedef enum logic [1:0] {
        TX_TRIG_EMPTY = 2'b00,
        TX_TRIG_1Q    = 2'b01,
        TX_TRIG_HALF  = 2'b10,
        TX_TRIG_3Q    = 2'b11
    } tx_trig_t;

endpackage

// ### pin_ctrl_if.sv
/*
 * bundle between the register logic and the port pin selector.
 * assumes both ends run on the same core clock.
 */
interface pin_ctrl_if;
    logic [15:0] sel;
    logic [7:0]  latch;
    logic [7:0]  func;
    logic [7:0]  pad_out;
    logic [7:0]  pad_oe;

    modport ctrl (output sel, output latch, output func,
                  input pad_out, input pad_oe);
    modport mux  (input sel, input latch, input func,
                  output pad_out, output pad_oe);
endinterface

// ### sync_2ff.sv
/*
 * two flip-flop synchroniser for a bus of independent levels.
 * assumes each bit may change at any time relative to core_clk.
 */
module sync_2ff
    import uart_irq_pkg::*;
#(
    parameter int W = 8
)
(
    // clock and reset
    input  wire logic         core_clk,
    input  wire logic         nrst,
    // levels
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            meta_reg <= '0;
            q        <= '0;
        end
        else
        begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule

// ### io_pin_mux.sv
/*
 * per-pin selector: general input, output latch bit or pin function.
 * latch-mode pins drive the complement of the latch bit.
 * assumes sel holds two bits per pin, pin 0 in the low pair.
 */
module io_pin_mux
    import uart_irq_pkg::*;
(
    // clock and reset
    input  wire logic core_clk,
    input  wire logic nrst,
    // control bundle
    pin_ctrl_if.mux   pins
);
    for (genvar i = 0; i < 8; i++)
    begin : g_pin
        pin_mode_t mode;
        assign mode = pin_mode_t'(pins.sel[2*i +: 2]);

        always_ff @(posedge core_clk)
        begin
            if (!nrst)
            begin
                pins.pad_out[i] <= 1'b0;
                pins.pad_oe[i]  <= 1'b0;
            end
            else
            begin
                unique case (mode)
                    PIN_LATCH:
                    begin
                        pins.pad_out[i] <= ~pins.latch[i];
                        pins.pad_oe[i]  <= 1'b1;
                    end
                    PIN_FUNCTION:
                    begin
                        pins.pad_out[i] <= pins.func[i];
                        pins.pad_oe[i]  <= 1'b1;
                    end
                    // reserved code leaves the pin undriven, like input
                    PIN_INPUT, PIN_RESERVED:
                    begin
                        pins.pad_out[i] <= 1'b0;
                        pins.pad_oe[i]  <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule

// ### uart_channel_irq_and_io_ctrl.sv
/*
 * one uart channel: interrupt source flags, enables, masked read,
 * active-low interrupt request, event interrupt, eight port pins.
 * assumes fifo levels and receiver events come from core_clk logic;
 * port pins are asynchronous and are synchronised here.
 */
// The register addresses and register access over Wishbone are this design's own decisions.
module uart_channel_irq_and_io_ctrl
    import uart_irq_pkg::*;
#(
    parameter int RX_DEPTH = 256,
    parameter int TX_DEPTH = 256,
    parameter int LVL_W    = 9
)
(
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             nrst,
    // wishbone slave
    input  wire logic [5:0]       wb_adr_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    input  wire logic             wb_we_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    output logic                  wb_ack_o,
    // receiver and transmitter events and levels
    input  wire logic             bit_tick,
    input  wire logic             rx_push,
    input  wire logic             rx_queue_read,
    input  wire logic [LVL_W-1:0] rx_level,
    input  wire logic [LVL_W-1:0] tx_level,
    input  wire logic             addr_match_event,
    input  wire logic             flow_char_event,
    input  wire logic [7:0]       flow_char_status,
    input  wire logic             break_change_event,
    // pin functions from the channel data paths
    input  wire logic             rts_n,
    input  wire logic             dtr_n,
    input  wire logic             dsr_n,
    input  wire logic             rx_dma_req_n,
    // port pins
    input  wire logic [7:0]       io_in,
    output logic      [7:0]       io_out,
    output logic      [7:0]       io_oe,
    // interrupts
    output logic                  interrupt_request_low,
    output logic                  irq_event
);
    localparam logic [LVL_W-1:0] RX_FULL_LVL = LVL_W'(RX_DEPTH);
    localparam logic [LVL_W-1:0] RX_HALF_LVL = LVL_W'(RX_DEPTH / 2);
    localparam logic [LVL_W-1:0] RX_3Q_LVL   = LVL_W'((RX_DEPTH * 3) / 4);
    localparam logic [LVL_W-1:0] TX_1Q_LVL   = LVL_W'(TX_DEPTH / 4);
    localparam logic [LVL_W-1:0] TX_HALF_LVL = LVL_W'(TX_DEPTH / 2);
    localparam logic [LVL_W-1:0] TX_3Q_LVL   = LVL_W'((TX_DEPTH * 3) / 4);

    logic [7:0]  port_pins_low_select_reg;
    logic [7:0]  port_pins_high_select_reg;
    logic [7:0]  interrupt_source_enables_reg;
    logic [7:0]  mode_reg;
    logic [7:0]  output_port_latch_reg;
    logic [7:0]  evt_flags_reg;
    logic [7:0]  evt_mask_reg;
    logic [7:0]  prev_flags_reg;
    logic        input_change_reg;
    logic        watchdog_reg;
    logic        addr_match_reg;
    logic        flow_char_reg;
    logic        break_change_reg;
    logic        rx_ready_reg;
    logic [6:0]  idle_count_reg;
    logic [1:0]  io_prev_reg;
    logic [7:0]  input_port_value;
    logic [7:0]  interrupt_source_flags;
    logic        tx_ready;
    logic        access;
    logic        wr_access;
    logic        rd_access;
    logic [7:0]  wr_byte;
    logic [7:0]  rd_next;
    logic        cmd_write;
    logic        rd_input_port;
    logic        rd_flow_stat;
    logic        rd_evt_flags;
    logic        rx_fifo_event;
    logic        pin_change;
    logic [7:0]  evt_rise;
    rx_trig_t    receive_trigger_select;
    tx_trig_t    transmit_trigger_select;
    logic        masked_status_read_enable;

    pin_ctrl_if pins ();

    sync_2ff #(
        .W (8)
    ) u_sync (
        .core_clk (core_clk),
        .nrst     (nrst),
        .d        (io_in),
        .q        (input_port_value)
    );

    io_pin_mux u_mux (
        .core_clk (core_clk),
        .nrst     (nrst),
        .pins     (pins)
    );

    assign masked_status_read_enable = mode_reg[MODE_MASKED_READ_BIT];
    assign receive_trigger_select =
        rx_trig_t'(mode_reg[MODE_RX_TRIG_LSB +: 2]);
    assign transmit_trigger_select =
        tx_trig_t'(mode_reg[MODE_TX_TRIG_LSB +: 2]);

    // bus decode; side effects happen on the edge that raises ack
    assign access    = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_access = access && wb_we_i && wb_sel_i[0];
    assign rd_access = access && !wb_we_i;
    assign wr_byte   = wb_dat_i[7:0];
    assign cmd_write = wr_access && (wb_adr_i == OFS_COMMAND);
    assign rd_input_port = rd_access && (wb_adr_i == OFS_IN_PORT);
    assign rd_flow_stat  = rd_access && (wb_adr_i == OFS_FLOW_STAT);
    assign rd_evt_flags  = rd_access && (wb_adr_i == OFS_EVT_FLAGS);

    // pin muxing
    assign pins.sel   = {port_pins_high_select_reg,
                         port_pins_low_select_reg};
    assign pins.latch = output_port_latch_reg;
    // function outputs are active low on the pins
    assign pins.func  = {1'b1,                               // pin 7
                         rx_dma_req_n,
                         dsr_n,
                         dtr_n,
                         ~interrupt_source_flags[ST_TX_READY],
                         2'b11,                              // pins 2, 1
                         rts_n};
    assign io_out = pins.pad_out;
    assign io_oe  = pins.pad_oe;

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end
        else
        begin
            wb_ack_o <= access;
            if (rd_access)
                wb_dat_o <= {24'h000000, rd_next};
        end
    end

    always_comb
    begin
        unique case (wb_adr_i)
            OFS_LOW_SEL:   rd_next = port_pins_low_select_reg;
            OFS_HIGH_SEL:  rd_next = port_pins_high_select_reg;
            OFS_FLAGS:
                if (masked_status_read_enable)
                    rd_next = interrupt_source_flags &
                              interrupt_source_enables_reg;
                else
                    rd_next = interrupt_source_flags;
            OFS_ENABLES:   rd_next = interrupt_source_enables_reg;
            OFS_MODE:      rd_next = mode_reg;
            OFS_OUT_LATCH: rd_next = output_port_latch_reg;
            OFS_IN_PORT:   rd_next = input_port_value;
            OFS_EVT_FLAGS: rd_next = evt_flags_reg;
            OFS_EVT_MASK:  rd_next = evt_mask_reg;
            OFS_FLOW_STAT: rd_next = flow_char_status;
            default:       rd_next = 8'h00;
        endcase
    end

    // software written configuration
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            port_pins_low_select_reg     <= RST_BYTE;
            port_pins_high_select_reg    <= RST_BYTE;
            interrupt_source_enables_reg <= RST_BYTE;
            mode_reg                     <= RST_BYTE;
            output_port_latch_reg        <= RST_BYTE;
            evt_mask_reg                 <= RST_BYTE;
        end
        else if (wr_access)
        begin
            unique case (wb_adr_i)
                OFS_LOW_SEL:   port_pins_low_select_reg <= wr_byte;
                OFS_HIGH_SEL:  port_pins_high_select_reg <= wr_byte;
                OFS_ENABLES:   interrupt_source_enables_reg <= wr_byte;
                OFS_MODE:      mode_reg <= wr_byte;
                OFS_OUT_LATCH: output_port_latch_reg <= wr_byte;
                OFS_EVT_MASK:  evt_mask_reg <= wr_byte;
                default:       ;
            endcase
        end
    end

    // input change on pins 0 and 1
    assign pin_change = |(input_port_value[1:0] ^ io_prev_reg);

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            io_prev_reg      <= 2'b00;
            input_change_reg <= 1'b0;
        end
        else
        begin
            io_prev_reg <= input_port_value[1:0];
            // a change seen in the clearing cycle is kept
            if (pin_change)
                input_change_reg <= 1'b1;
            else if (rd_input_port)
                input_change_reg <= 1'b0;
        end
    end

    // receiver idle watchdog
    assign rx_fifo_event = rx_push || rx_queue_read;

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            idle_count_reg <= 7'h00;
            watchdog_reg   <= 1'b0;
        end
        else if (rx_fifo_event)
        begin
            idle_count_reg <= 7'h00;
            watchdog_reg   <= 1'b0;
        end
        else if (bit_tick)
        begin
            // counter stops past the limit so it cannot wrap and refire
            if (idle_count_reg <= WATCHDOG_BIT_TIMES)
                idle_count_reg <= idle_count_reg + 7'h01;
            if (idle_count_reg == WATCHDOG_BIT_TIMES)
                watchdog_reg <= 1'b1;
        end
    end

    // receiver event flags
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            addr_match_reg   <= 1'b0;
            flow_char_reg    <= 1'b0;
            break_change_reg <= 1'b0;
        end
        else
        begin
            if (addr_match_event)
                addr_match_reg <= 1'b1;
            else if (cmd_write &&
                     wr_byte[4:0] == CMD_RESET_ADDR_STATUS)
                addr_match_reg <= 1'b0;
            if (flow_char_event)
                flow_char_reg <= 1'b1;
            else if (rd_flow_stat)
                flow_char_reg <= 1'b0;
            if (break_change_event)
                break_change_reg <= 1'b1;
            else if (cmd_write &&
                     wr_byte[4:0] == CMD_RESET_BREAK_CHANGE)
                break_change_reg <= 1'b0;
        end
    end

    // receiver ready per trigger mode
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            rx_ready_reg <= 1'b0;
        else
        begin
            unique case (receive_trigger_select)
                RX_TRIG_READY:
                    if (rx_push)
                        rx_ready_reg <= 1'b1;
                    else if (rx_queue_read &&
                             rx_level == LVL_W'(1))
                        rx_ready_reg <= 1'b0;
                RX_TRIG_FULL:
                    // a held character pushed after a read refills it
                    if (rx_push && rx_level == RX_FULL_LVL - LVL_W'(1))
                        rx_ready_reg <= 1'b1;
                    else if (rx_level != RX_FULL_LVL)
                        rx_ready_reg <= 1'b0;
                RX_TRIG_3Q:
                    rx_ready_reg <= (rx_level >= RX_3Q_LVL);
                RX_TRIG_HALF:
                    rx_ready_reg <= (rx_level >= RX_HALF_LVL);
            endcase
        end
    end

    // transmitter ready follows the level directly
    always_comb
    begin
        unique case (transmit_trigger_select)
            TX_TRIG_EMPTY: tx_ready = (tx_level == '0);
            TX_TRIG_1Q:    tx_ready = (tx_level < TX_1Q_LVL);
            TX_TRIG_HALF:  tx_ready = (tx_level < TX_HALF_LVL);
            TX_TRIG_3Q:    tx_ready = (tx_level < TX_3Q_LVL);
        endcase
    end

    assign interrupt_source_flags = {input_change_reg,
                                     watchdog_reg,
                                     addr_match_reg,
                                     flow_char_reg,
                                     1'b0,
                                     break_change_reg,
                                     rx_ready_reg,
                                     tx_ready};

    // request output registered; enable bit 3 gates a constant zero
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            interrupt_request_low <= 1'b1;
        else
            interrupt_request_low <= ~|(interrupt_source_flags &
                interrupt_source_enables_reg);
    end

    // sticky event flags: rising edge of each source flag
    assign evt_rise = interrupt_source_flags & ~prev_flags_reg;

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            prev_flags_reg <= RST_BYTE;
            evt_flags_reg  <= RST_BYTE;
        end
        else
        begin
            prev_flags_reg <= interrupt_source_flags;
            if (rd_evt_flags)
                evt_flags_reg <= evt_rise;
            else
                evt_flags_reg <= evt_flags_reg | evt_rise;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            irq_event <= 1'b0;
        else
            irq_event <= |(evt_flags_reg & evt_mask_reg);
    end

endmodule

// ### host_cpu_model.sv
/* host model: classic wishbone master, one single cycle per call.
   assumes the slave always answers; the bench bounds every wait. */
module host_cpu_model
(
    // clock
    input  wire logic        core_clk,
    // wishbone master side
    output logic      [5:0]  adr,
    output logic      [31:0] dat_w,
    output logic             we,
    output logic      [3:0]  sel,
    output logic             cyc,
    output logic             stb,
    input  wire logic [31:0] dat_r,
    input  wire logic        ack
);
    initial
    begin
        {adr, dat_w, we, sel, cyc, stb} = 45'h0;
    end

    task automatic xfer(input logic [5:0] a, input logic w,
                        input logic [7:0] d, output logic [7:0] q);
        @(posedge core_clk);
        adr <= a;
        we <= w;
        dat_w <= {24'h000000, d};
        sel <= 4'hF;
        cyc <= 1'b1;
        stb <= 1'b1;
        // nothing moves until ack is seen at an edge
        do
            @(posedge core_clk);
        while (ack !== 1'b1);
        q = dat_r[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
endmodule

// ### uart_channel_irq_and_io_ctrl_properties.sv
/* concurrent checks on the channel block's ports.
   assumes a bus master that holds each request until ack. */
module uart_channel_irq_and_io_ctrl_properties
    import uart_irq_pkg::*;
(
    // clock, reset, bus
    input wire logic        core_clk,
    input wire logic        nrst,
    input wire logic [5:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_we_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic        wb_ack_o,
    // events and outputs
    input wire logic        addr_match_event,
    input wire logic        break_change_event,
    input wire logic [7:0]  io_oe,
    input wire logic        interrupt_request_low
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    // shadows lag the registers by one edge, as do pins and request
    logic [7:0] lo_reg, hi_reg, en_reg;
    logic       wr;
    assign wr = wb_ack_o && wb_we_i && wb_sel_i[0];

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            {lo_reg, hi_reg, en_reg} <= 24'h000000;
        else if (wr && wb_adr_i == OFS_LOW_SEL)
            lo_reg <= wb_dat_i[7:0];
        else if (wr && wb_adr_i == OFS_HIGH_SEL)
            hi_reg <= wb_dat_i[7:0];
        else if (wr && wb_adr_i == OFS_ENABLES)
            en_reg <= wb_dat_i[7:0];
    end

    a_pin3_drive: assert property (
        io_oe[3] == ^lo_reg[7:6])
        else $error("pin 3 enable wrong");
    a_pin0_drive: assert property (
        io_oe[0] == ^lo_reg[1:0])
        else $error("pin 0 enable wrong");
    a_pin6_drive: assert property (
        io_oe[6] == ^hi_reg[5:4])
        else $error("pin 6 enable wrong");
    a_pin4_drive: assert property (
        io_oe[4] == ^hi_reg[1:0])
        else $error("pin 4 enable wrong");
    a_mask_gate: assert property (
        en_reg == 8'h00 |-> interrupt_request_low)
        else $error("request without enabled source");
    a_break_req: assert property (
        break_change_event && en_reg[2] |-> ##2 !interrupt_request_low)
        else $error("break did not raise request");
    a_addr_req: assert property (
        addr_match_event && en_reg[5] |-> ##2 !interrupt_request_low)
        else $error("address match did not raise request");
    a_flag3_zero: assert property (
        wb_ack_o && !wb_we_i && wb_adr_i == OFS_FLAGS |-> !wb_dat_o[3])
        else $error("reserved flag read as one");
endmodule

bind uart_channel_irq_and_io_ctrl uart_channel_irq_and_io_ctrl_properties
    props (.core_clk, .nrst, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i,
           .wb_sel_i, .wb_ack_o, .addr_match_event, .break_change_event,
           .io_oe, .interrupt_request_low);

// ### uart_channel_irq_and_io_ctrl_test.sv
/* bench: resets the block, drives bus cycles through the host model
   and events directly, then judges flags, request and pins.
   assumes one-cycle bus answers and flag updates of the block. */
module uart_channel_irq_and_io_ctrl_test
    import uart_irq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int D = 256;
    logic        core_clk = 1'b0;
    logic        nrst = 1'b0;
    logic [5:0]  adr;
    logic [31:0] dat_w, dat_r;
    logic [3:0]  sel;
    logic        we, cyc, stb, ack, interrupt_request_low, irq_event;
    logic [5:0]  ev = 6'h00;
    logic [3:0]  fn_n = 4'hF;
    logic [8:0]  rx_level = 9'h000, tx_level = 9'h000;
    logic [7:0]  io_in = 8'h00, io_out, io_oe, q;
    int          failures = 0, checked = 0;

    always #5 core_clk = ~core_clk;

    host_cpu_model host (.core_clk, .adr, .dat_w, .we, .sel, .cyc, .stb,
                         .dat_r, .ack);
    uart_channel_irq_and_io_ctrl #(.RX_DEPTH(D), .TX_DEPTH(D)) dut (
        .core_clk, .nrst, .wb_adr_i(adr), .wb_dat_i(dat_w),
        .wb_dat_o(dat_r), .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_ack_o(ack), .bit_tick(ev[5]),
        .rx_push(ev[3]), .rx_queue_read(ev[4]), .rx_level, .tx_level,
        .addr_match_event(ev[1]), .flow_char_event(ev[2]),
        .flow_char_status(8'h5A), .break_change_event(ev[0]),
        .rts_n(fn_n[0]), .dtr_n(fn_n[1]), .dsr_n(fn_n[2]),
        .rx_dma_req_n(fn_n[3]),
        .io_in, .io_out, .io_oe, .interrupt_request_low, .irq_event
    );

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic fl(input logic [7:0] m, input logic [7:0] e);
        host.xfer(OFS_FLAGS, 1'b0, 8'h00, q);
        chk(q & m, e);
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        host.xfer(a, 1'b1, d, q);
    endtask

    task automatic pulse(input int i);
        @(posedge core_clk);
        ev[i] <= 1'b1;
        @(posedge core_clk);
        ev[i] <= 1'b0;
    endtask

    task automatic sc_reset;
        fl(8'hFF, 8'h01);
        host.xfer(OFS_ENABLES, 1'b0, 8'h00, q);
        chk(q, RST_BYTE);
        host.xfer(6'h3C, 1'b0, 8'h00, q);
        chk(q, 8'h00);
    endtask

    task automatic sc_pins;
        logic [7:0] x, y;
        // tx queue not empty, so pin 3 in function mode drives high
        tx_level <= 9'h001;
        fn_n <= 4'hA;
        wr(OFS_OUT_LATCH, 8'h79);
        for (int c = 0; c < 4; c++)
        begin
            wr(OFS_LOW_SEL, {c[1:0], 4'h0, c[1:0]});
            wr(OFS_HIGH_SEL, {2'b00, c[1:0], c[1:0], c[1:0]});
            repeat (2) @(posedge core_clk);
            x = (c == 2) ? 8'h58 : 8'h00;
            y = (c == 1 || c == 2) ? 8'h79 : 8'h00;
            chk(io_oe, y);
            chk(io_out, x);
        end
    endtask

    task automatic sc_irq;
        pulse(2);
        fl(8'h10, 8'h10);
        wr(OFS_ENABLES, 8'h24);
        repeat (2) @(posedge core_clk);
        chk({7'h00, interrupt_request_low}, 8'h01);
        pulse(0);
        pulse(1);
        chk({7'h00, interrupt_request_low}, 8'h00);
        wr(OFS_MODE, 8'h01);
        fl(8'hFF, 8'h24);
        wr(OFS_MODE, 8'h00);
        host.xfer(OFS_FLOW_STAT, 1'b0, 8'h00, q);
        chk(q, 8'h5A);
        fl(8'h10, 8'h00);
        wr(OFS_COMMAND, 8'h3B);
        fl(8'h24, 8'h04);
        wr(OFS_COMMAND, {3'h0, CMD_RESET_BREAK_CHANGE});
        fl(8'h04, 8'h00);
        chk({7'h00, interrupt_request_low}, 8'h01);
    endtask

    task automatic sc_event;
        host.xfer(OFS_EVT_FLAGS, 1'b0, 8'h00, q);
        wr(OFS_EVT_MASK, 8'h04);
        pulse(0);
        repeat (3) @(posedge core_clk);
        chk({7'h00, irq_event}, 8'h01);
        host.xfer(OFS_EVT_FLAGS, 1'b0, 8'h00, q);
        chk(q & 8'h04, 8'h04);
        repeat (2) @(posedge core_clk);
        chk({7'h00, irq_event}, 8'h00);
    endtask

    task automatic sc_input;
        io_in <= 8'h02;
        repeat (6) @(posedge core_clk);
        fl(8'h80, 8'h80);
        host.xfer(OFS_IN_PORT, 1'b0, 8'h00, q);
        chk(q, 8'h02);
        fl(8'h80, 8'h00);
    endtask

    task automatic sc_watchdog;
        pulse(3);
        rx_level <= 9'h001;
        repeat (64) pulse(5);
        fl(8'h42, 8'h02);
        pulse(5);
        fl(8'h42, 8'h42);
        pulse(4);
        fl(8'h42, 8'h00);
    endtask

    task automatic sc_trig;
        int tm[8] = '{8'h00, 8'h00, 8'h10, 8'h10, 8'h14, 8'h14, 8'h18, 8'h18};
        int tr[8] = '{0, 0, 0, 0, D / 2, D / 2 - 1, D * 3 / 4, D * 3 / 4 - 1};
        int tt[8] = '{1, 0, D / 4 - 1, D / 4, D / 4, D / 4, D / 4 - 1, 0};
        int te[8] = '{0, 1, 1, 0, 2, 0, 3, 1};
        for (int i = 0; i < 8; i++)
        begin
            rx_level <= 9'(tr[i]);
            tx_level <= 9'(tt[i]);
            wr(OFS_MODE, 8'(tm[i]));
            fl(8'h03, 8'(te[i]));
        end
        rx_level <= 9'(D - 1);
        wr(OFS_MODE, 8'h0C);
        pulse(3);
        rx_level <= 9'(D);
        fl(8'h02, 8'h02);
        rx_level <= 9'(D - 1);
        fl(8'h02, 8'h00);
    endtask

    task automatic give_verdict;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        repeat (16) @(posedge core_clk);
        nrst <= 1'b1;
        sc_reset;
        sc_pins;
        sc_irq;
        sc_event;
        sc_input;
        sc_watchdog;
        sc_trig;
        give_verdict;
    end

    initial
    begin
        #50us;
        failures++;
        give_verdict;
    end
endmodule
